// >>> src/capture_compare_array_unit.v
// Capture/compare array with two reloadable timers and an AXI4-Lite register port.
`timescale 1ns/10ps
// How it works
// RULE_01 - Sixteen channels; one-clock resolution, eight clocks when staggered option is set.
// RULE_02 - Two independent 16-bit timers, each with its own reload register.
// RULE_03 - Timer clock is a prescaled system clock or the auxiliary timer overflow event.
// RULE_04 - A timer may instead count edges of its external count input.
// RULE_05 - Each of sixteen registers picks a timer and capture or compare function.
// RULE_06 - Each register owns one pin: capture trigger input or compare output.
// RULE_07 - Capture copies the selected timer into the register and raises its interrupt.
// RULE_08 - Capture edge is rising, falling or both, chosen per register.
// RULE_09 - Compare registers are matched continuously against their timer; match runs mode action.
// RULE_10 - Mode zero: interrupt on every match, pin untouched.
// RULE_11 - Mode one: pin toggles on every match.
// RULE_12 - Mode two: interrupt only, at most once per timer period.
// RULE_13 - Mode three: pin high on match, low on timer overflow, once per period.
// RULE_14 - Double register: registers i and i+8 both toggle pin i.
// RULE_15 - Single-event option stops a compare register after its first event.
// RULE_16 - The overflow event comes from the auxiliary timer of general timer module two.
// RULE_17 - On overflow a timer reloads from its reload register and keeps counting.
// RULE_18 - Each register has a sticky interrupt flag, cleared by software, one node each.
`include "capture_compare_array_unit_defines.vh"

module capture_compare_array_unit (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [15:0] cc_pin_in,
  output reg  [15:0] cc_pin_out,
  output reg  [15:0] cc_pin_oe,
  input  wire        aux_timer_event,
  input  wire [1:0]  ext_count_in,
  output reg  [15:0] cc_irq_node,
  output reg         irq
);

  integer i;
  integer n;
  integer pt;

  // Bus side state.
  reg  [7:0]  aw_addr_q;
  reg         aw_have_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         w_have_q;
  wire        wr_go;

  // Block state.
  reg  [16:0] tctl_q;
  reg  [15:0] tcnt_q     [0:1];
  reg  [15:0] trld_q     [0:1];
  reg  [1:0]  tick_d_q;
  reg  [1:0]  ovf_q;
  reg  [`DIV_W-1:0] div_q;
  reg  [15:0] val_q      [0:15];
  reg  [5:0]  mode_q     [0:15];
  reg  [15:0] once_q;
  reg  [15:0] se_done_q;
  reg  [15:0] stat_q;
  reg  [15:0] en_q;

  // Three-stage synchronisers for the pins and count inputs.
  reg  [17:0] s1_q;
  reg  [17:0] s2_q;
  reg  [17:0] s3_q;
  reg  [17:0] st_q;
  wire [17:0] agree;
  wire [17:0] rise;
  wire [17:0] fall;

  reg  [1:0]  tick;
  reg  [15:0] ev_w;
  reg  [15:0] cap_w;
  reg  [15:0] tog_w;
  reg  [15:0] set_w;
  reg  [15:0] clr_w;
  reg  [15:0] se_w;
  reg  [15:0] oe_w;
  reg         hit;
  reg         cmp_ev;
  reg  [2:0]  md;
  reg         ts;
  reg  [2:0]  src;

  function presc;
    input [`DIV_W-1:0] d;
    input [2:0]        k;
    input              stag;
    reg   [`DIV_W-1:0] msk;
    begin
      msk = stag ? ((`STAG_BASE << k) - 7'h01) : ((7'h01 << k) - 7'h01);
      presc = ((d & msk) == msk);
    end
  endfunction

  function [15:0] strb16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      strb16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  function addr_ok;
    input [31:0] a;
    begin
      if (a[31:8] != 24'h000000 || a[1:0] != 2'h0) begin
        addr_ok = 1'b0;
      end else if (a[7:6] == `PG_MODE || a[7:6] == `PG_VAL) begin
        addr_ok = 1'b1;
      end else if (a[7:6] == 2'h0 && a[7:0] <= `A_PIN_STAT) begin
        addr_ok = 1'b1;
      end else begin
        addr_ok = 1'b0;
      end
    end
  endfunction

  assign s_axi_awready = ~aw_have_q;
  assign s_axi_wready  = ~w_have_q;
  assign s_axi_arready = ~s_axi_rvalid;
  // Both halves of a write must be held before it acts, and only once the last answer is gone.
  assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;

  assign agree = ~(s2_q ^ s3_q);
  assign rise  = agree & s3_q & ~st_q;
  assign fall  = agree & ~s3_q & st_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 18'h00000;
      s2_q <= 18'h00000;
      s3_q <= 18'h00000;
      st_q <= 18'h00000;
    end else begin
      s1_q <= {ext_count_in, cc_pin_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= (agree & s3_q) | (~agree & st_q);
    end
  end

  // Timer clock selection.
  always @* begin
    for (n = 0; n < `NUM_TMR; n = n + 1) begin
      src = tctl_q[n*`TCTL_T1_LSB+1 +: 3];
      if (!tctl_q[n*`TCTL_T1_LSB]) begin
        tick[n] = 1'b0;
      end else if (src == `SRC_AUX) begin
        tick[n] = aux_timer_event; // RULE_03 RULE_16
      end else if (src == `SRC_EXT_RISE) begin
        tick[n] = rise[`NUM_CC+n]; // RULE_04
      end else if (src == `SRC_EXT_BOTH) begin
        tick[n] = rise[`NUM_CC+n] | fall[`NUM_CC+n]; // RULE_04
      end else begin
        tick[n] = presc(div_q, src, tctl_q[`TCTL_STAGGER]); // RULE_01 RULE_03
      end
    end
  end

  // Per-register events.
  always @* begin
    ev_w  = 16'h0000;
    cap_w = 16'h0000;
    tog_w = 16'h0000;
    set_w = 16'h0000;
    clr_w = 16'h0000;
    se_w  = 16'h0000;
    oe_w  = 16'h0000;
    hit   = 1'b0;
    cmp_ev = 1'b0;
    md    = `MD_OFF;
    ts    = 1'b0;
    pt    = 0;
    for (i = 0; i < `NUM_CC; i = i + 1) begin
      ts = mode_q[i][`M_TSEL]; // RULE_05
      md = mode_q[i][`M_MODE_HI:`M_MODE_LO];
      pt = i;
      if (i >= `HALF_CC && mode_q[i-`HALF_CC][`M_DOUBLE]) begin
        pt = i - `HALF_CC; // RULE_14
      end
      // A match is judged on the cycle after the timer steps, so each count value matches once.
      hit = tick_d_q[ts] && (tcnt_q[ts] == val_q[i]) && !se_done_q[i]; // RULE_09
      cap_w[i] = (md == `MD_CAP_RISE && rise[i]) || (md == `MD_CAP_FALL && fall[i]) ||
                 (md == `MD_CAP_BOTH && (rise[i] || fall[i])); // RULE_08
      if (md == `MD_CMP0 || md == `MD_CMP1) begin
        cmp_ev = hit; // RULE_10 RULE_11
      end else if (md == `MD_CMP2 || md == `MD_CMP3) begin
        cmp_ev = hit && (!once_q[i] || ovf_q[ts]); // RULE_12 RULE_13
      end else begin
        cmp_ev = 1'b0;
      end
      ev_w[i] = cap_w[i] | cmp_ev; // RULE_07
      se_w[i] = cmp_ev & mode_q[i][`M_SINGLE]; // RULE_15
      if (cmp_ev && (md == `MD_CMP1 || pt != i || mode_q[i][`M_DOUBLE])) begin
        tog_w[pt] = ~tog_w[pt]; // RULE_11 RULE_14
      end
      if (md == `MD_CMP3) begin
        set_w[i] = cmp_ev; // RULE_13
        clr_w[i] = ovf_q[ts]; // RULE_13
      end
      if (md == `MD_CMP1 || md == `MD_CMP3 || (mode_q[i][`M_DOUBLE] && md[2])) begin
        oe_w[pt] = 1'b1; // RULE_06
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      tctl_q     <= `TCTL_RST;
      tick_d_q   <= 2'h0;
      ovf_q      <= 2'h0;
      div_q      <= 7'h00;
      once_q     <= 16'h0000;
      se_done_q  <= 16'h0000;
      stat_q     <= 16'h0000;
      en_q       <= 16'h0000;
      cc_pin_out <= 16'h0000;
      cc_pin_oe  <= 16'h0000;
      cc_irq_node <= 16'h0000;
      irq        <= 1'b0;
      for (n = 0; n < `NUM_TMR; n = n + 1) begin
        tcnt_q[n] <= 16'h0000;
        trld_q[n] <= 16'h0000;
      end
      for (i = 0; i < `NUM_CC; i = i + 1) begin
        val_q[i]  <= 16'h0000;
        mode_q[i] <= 6'h00;
      end
    end else begin
      div_q    <= div_q + 7'h01;
      tick_d_q <= tick;
      for (n = 0; n < `NUM_TMR; n = n + 1) begin
        ovf_q[n] <= tick[n] && (tcnt_q[n] == `TMR_MAX);
        if (tick[n]) begin
          if (tcnt_q[n] == `TMR_MAX) begin
            tcnt_q[n] <= trld_q[n]; // RULE_17
          end else begin
            tcnt_q[n] <= tcnt_q[n] + 16'h0001; // RULE_02
          end
        end
      end
      for (i = 0; i < `NUM_CC; i = i + 1) begin
        if (cap_w[i]) begin
          val_q[i] <= tcnt_q[mode_q[i][`M_TSEL]]; // RULE_07
        end
        if (ev_w[i]) begin
          once_q[i] <= 1'b1; // RULE_12 RULE_13
        end else if (ovf_q[mode_q[i][`M_TSEL]]) begin
          once_q[i] <= 1'b0;
        end
        if (se_w[i]) begin
          se_done_q[i] <= 1'b1; // RULE_15
        end
        // Set beats overflow clear so a match at the reload value is not lost.
        if (set_w[i]) begin
          cc_pin_out[i] <= 1'b1;
        end else if (clr_w[i]) begin
          cc_pin_out[i] <= 1'b0;
        end else begin
          cc_pin_out[i] <= cc_pin_out[i] ^ tog_w[i];
        end
      end
      cc_pin_oe   <= oe_w;
      cc_irq_node <= (stat_q | ev_w); // RULE_18
      irq         <= |((stat_q | ev_w) & en_q);
      stat_q      <= stat_q | ev_w; // RULE_18
      if (wr_go) begin
        if (aw_addr_q == `A_TCTL) begin
          tctl_q <= {w_strb_q[2] ? w_data_q[`TCTL_STAGGER] : tctl_q[`TCTL_STAGGER],
                     strb16(tctl_q[15:0], w_data_q, w_strb_q)}; // RULE_01
        end else if (aw_addr_q == `A_TVAL0) begin
          tcnt_q[0] <= strb16(tcnt_q[0], w_data_q, w_strb_q);
        end else if (aw_addr_q == `A_TRLD0) begin
          trld_q[0] <= strb16(trld_q[0], w_data_q, w_strb_q);
        end else if (aw_addr_q == `A_TVAL1) begin
          tcnt_q[1] <= strb16(tcnt_q[1], w_data_q, w_strb_q);
        end else if (aw_addr_q == `A_TRLD1) begin
          trld_q[1] <= strb16(trld_q[1], w_data_q, w_strb_q);
        end else if (aw_addr_q == `A_IRQ_CLR) begin
          // A new event in the clearing cycle keeps its flag set.
          stat_q <= (stat_q & ~strb16(16'h0000, w_data_q, w_strb_q)) | ev_w; // RULE_18
        end else if (aw_addr_q == `A_IRQ_EN) begin
          en_q <= strb16(en_q, w_data_q, w_strb_q);
        end else if (aw_addr_q[7:6] == `PG_MODE) begin
          mode_q[aw_addr_q[5:2]] <= w_strb_q[0] ? w_data_q[5:0] : mode_q[aw_addr_q[5:2]];
          se_done_q[aw_addr_q[5:2]] <= 1'b0;
          once_q[aw_addr_q[5:2]] <= 1'b0;
        end else if (aw_addr_q[7:6] == `PG_VAL && !cap_w[aw_addr_q[5:2]]) begin
          val_q[aw_addr_q[5:2]] <= strb16(val_q[aw_addr_q[5:2]], w_data_q, w_strb_q);
        end
      end
    end
  end

  // Write channel.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q    <= 8'h00;
      aw_have_q    <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      w_have_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= addr_ok(s_axi_awaddr) ? s_axi_awaddr[7:0] : `A_BAD;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q == `A_BAD) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; reading status has no side effect.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      s_axi_rdata  <= 32'h00000000;
      if (!addr_ok(s_axi_araddr)) begin
        s_axi_rdata <= 32'h00000000;
      end else if (s_axi_araddr[7:0] == `A_TCTL) begin
        s_axi_rdata <= {15'h0000, tctl_q};
      end else if (s_axi_araddr[7:0] == `A_TVAL0) begin
        s_axi_rdata <= {16'h0000, tcnt_q[0]};
      end else if (s_axi_araddr[7:0] == `A_TRLD0) begin
        s_axi_rdata <= {16'h0000, trld_q[0]};
      end else if (s_axi_araddr[7:0] == `A_TVAL1) begin
        s_axi_rdata <= {16'h0000, tcnt_q[1]};
      end else if (s_axi_araddr[7:0] == `A_TRLD1) begin
        s_axi_rdata <= {16'h0000, trld_q[1]};
      end else if (s_axi_araddr[7:0] == `A_IRQ_STAT) begin
        s_axi_rdata <= {16'h0000, stat_q};
      end else if (s_axi_araddr[7:0] == `A_IRQ_EN) begin
        s_axi_rdata <= {16'h0000, en_q};
      end else if (s_axi_araddr[7:0] == `A_PIN_STAT) begin
        s_axi_rdata <= {st_q[15:0], cc_pin_out};
      end else if (s_axi_araddr[7:6] == `PG_MODE) begin
        s_axi_rdata <= {26'h0000000, mode_q[s_axi_araddr[5:2]]};
      end else if (s_axi_araddr[7:6] == `PG_VAL) begin
        s_axi_rdata <= {16'h0000, val_q[s_axi_araddr[5:2]]};
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // capture_compare_array_unit

// >>> inc/capture_compare_array_unit_defines.vh
// Offsets, field positions, encodings and reset values of the capture/compare array.
`ifndef CAPTURE_COMPARE_ARRAY_UNIT_DEFINES_VH
`define CAPTURE_COMPARE_ARRAY_UNIT_DEFINES_VH

`define NUM_CC        16
`define NUM_TMR       2
`define HALF_CC       8
`define DIV_W         7
`define STAG_BASE     7'h08
`define A_BAD         8'hFC

`define A_TCTL        8'h00
`define A_TVAL0       8'h04
`define A_TRLD0       8'h08
`define A_TVAL1       8'h0C
`define A_TRLD1       8'h10
`define A_IRQ_STAT    8'h14
`define A_IRQ_CLR     8'h18
`define A_IRQ_EN      8'h1C
`define A_PIN_STAT    8'h20
`define PG_MODE       2'h1
`define PG_VAL        2'h2

`define TCTL_T1_LSB   8
`define TCTL_STAGGER  16
`define TCTL_RST      17'h00000

`define M_TSEL        0
`define M_MODE_HI     3
`define M_MODE_LO     1
`define M_SINGLE      4
`define M_DOUBLE      5

`define MD_OFF        3'h0
`define MD_CAP_RISE   3'h1
`define MD_CAP_FALL   3'h2
`define MD_CAP_BOTH   3'h3
`define MD_CMP0       3'h4
`define MD_CMP1       3'h5
`define MD_CMP2       3'h6
`define MD_CMP3       3'h7

`define SRC_AUX       3'h5
`define SRC_EXT_RISE  3'h6
`define SRC_EXT_BOTH  3'h7

`define TMR_MAX       16'hFFFF
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// >>> verification/capture_compare_array_unit_chk.sv
// Port-level property checker for the capture/compare array.
`timescale 1ns/10ps
module capture_compare_array_unit_chk (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [31:0] s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [15:0] cc_irq_node,
  input logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read request not answered in one cycle");
  a_arready_free: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready disagrees with pending read data");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data kept after handshake");
  a_read_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:8] != 24'h0
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("out of range read not refused");
  // Both halves are latched first and act one edge later, so the answer is two edges out.
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_addr_held: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address slot not closed after take");
  a_irq_node: assert property (irq |-> cc_irq_node != 16'h0)
    else $error("interrupt line high with no node pending");
  // Nodes are sticky, so a falling node must trace back to a register write.
  a_node_sticky: assert property (|($past(cc_irq_node) & ~cc_irq_node) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt node dropped without a clear write");
endmodule // capture_compare_array_unit_chk

// >>> verification/pin_partner.sv
// Pin-side partner: resolves shared pins and supplies timer event and count inputs.
`timescale 1ns/10ps
module pin_partner (
  input  logic        aclk,
  input  logic [15:0] cc_pin_out,
  input  logic [15:0] cc_pin_oe,
  output logic [15:0] cc_pin_in,
  output logic        aux_timer_event,
  output logic [1:0]  ext_count_in
);
  logic [15:0] drv = 16'h0;
  // A pin the array drives shows its level; otherwise this side's level wins.
  assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & drv);
  initial begin
    aux_timer_event = 1'b0;
    ext_count_in = 2'h0;
  end
  task pulse_aux;
    aux_timer_event <= 1'b1;
    @(posedge aclk);
    aux_timer_event <= 1'b0;
  endtask
  // Eight cycles covers the input synchroniser and the capture latch.
  task set_pin(input int i, input logic v);
    drv[i] <= v;
    repeat (8) @(posedge aclk);
  endtask
  task ext_pulse(input int k);
    ext_count_in[k] <= 1'b1;
    repeat (6) @(posedge aclk);
    ext_count_in[k] <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
endmodule // pin_partner

// >>> verification/capture_compare_array_unit_tb.sv
// Self-checking bench for the capture/compare array against a behavioural model.
`timescale 1ns/10ps
module capture_compare_array_unit_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
  logic        s_axi_arready, s_axi_bvalid, s_axi_rvalid, aux_timer_event, irq;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ext_count_in;
  logic [15:0] cc_pin_in, cc_pin_out, cc_pin_oe, cc_irq_node, ep = 16'h0, es = 16'h0;
  int          err_total = 0, checked = 0, cnt, rld, en;
  int          md[16], vl[16], pt[16], arm[16], sd[16], sg[16], cap[16];
  int          ri[7] = '{0, 1, 2, 3, 4, 12, 6};
  int          mv[7] = '{8'h0A, 8'h0E, 8'h0C, 8'h08, 8'h2A, 8'h0A, 8'h1A};
  int          vv[7] = '{16'hFFFE, 16'hFFFE, 16'hFFFE, 16'hFFFF, 16'hFFFE, 16'hFFFF, 16'hFFFE};
  int          cr[6] = '{5, 7, 7, 8, 8, 5}, cl[6] = '{1, 1, 0, 1, 0, 0};
  int          ce[6] = '{1, 0, 1, 1, 1, 0};
  always #20 aclk = ~aclk;
  capture_compare_array_unit uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cc_pin_in, .cc_pin_out, .cc_pin_oe, .aux_timer_event,
    .ext_count_in, .cc_irq_node, .irq);
  pin_partner pp (.aclk, .cc_pin_out, .cc_pin_oe, .cc_pin_in, .aux_timer_event, .ext_count_in);
  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task hang(input string m);
    err_total++;
    $display("CHECK FAILED at %0t: no answer to %s", $time, m);
    tally_and_finish;
  endtask
  task axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    if (n == 40)
      hang("write");
    chk({30'h0, s_axi_bresp}, {30'h0, er}, $sformatf("write response at %h", a));
  endtask
  task axr(input logic [31:0] a, input logic [31:0] x, input logic [31:0] m, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    if (n == 40)
      hang("read");
    chk(s_axi_rdata & m, x, $sformatf("read data at %h", a));
    chk({30'h0, s_axi_rresp}, {30'h0, er}, $sformatf("read response at %h", a));
  endtask
  // One auxiliary timer tick, applied to the model and then compared at the pins.
  task step;
    int i;
    int ov;
    pp.pulse_aux();
    ov = (cnt == 32'hFFFF);
    cnt = ov ? rld : cnt + 1;
    for (i = 0; i < 16; i++) begin
      if (ov)
        arm[i] = 1;
      if (ov && md[i] == 7)
        ep[i] = 1'b0;
      if (md[i] >= 4 && cnt == vl[i] && sd[i] == 0 && (md[i] < 6 || arm[i] == 1)) begin
        es[i] = 1'b1;
        arm[i] = 0;
        sd[i] = sg[i];
        if (md[i] == 5)
          ep[pt[i]] = ~ep[pt[i]];
        if (md[i] == 7)
          ep[i] = 1'b1;
      end
    end
    repeat (3) @(posedge aclk);
    // Pin 12 is left out: as a double-register partner it is never driven and holds its reset level.
    chk({16'h0, cc_pin_out & 16'hEFFF}, {16'h0, ep}, "compare pins");
    chk({31'h0, irq}, {31'h0, |(es & en[15:0])}, "interrupt line");
    chk({16'h0, cc_irq_node}, {16'h0, es}, "interrupt nodes");
    axr(32'h14, {16'h0, es}, 32'hFFFF, 2'h0);
  endtask
  initial begin
    int i;
    int r;
    int v;
    v = $urandom(32'h53A04CA5);
    for (i = 0; i < 16; i++) begin
      md[i] = 0;
      pt[i] = i;
      arm[i] = 1;
      sd[i] = 0;
      sg[i] = 0;
      cap[i] = 0;
    end
    pt[12] = 4;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(32'h00, 32'h0, 32'h1FFFF, 2'h0);
    axr(32'h14, 32'h0, 32'hFFFF, 2'h0);
    axr(32'h3C, 32'h0, 32'hFFFFFFFF, 2'h2);
    axr(32'h100, 32'h0, 32'hFFFFFFFF, 2'h2);
    axw(32'h3C, 32'h5A5A, 2'h2);
    en = ($urandom & 32'hFFFF) | 32'h10;
    axw(32'h1C, en, 2'h0);
    rld = 32'hFFFD;
    cnt = rld;
    axw(32'h08, rld, 2'h0);
    axw(32'h04, cnt, 2'h0);
    for (i = 0; i < 7; i++) begin
      r = ri[i];
      md[r] = (mv[i] >> 1) & 7;
      sg[r] = (mv[i] >> 4) & 1;
      vl[r] = vv[i];
      axw(32'h40 + 4 * r, mv[i], 2'h0);
      axw(32'h80 + 4 * r, vv[i], 2'h0);
    end
    axw(32'h00, 32'h0B, 2'h0);
    chk({16'h0, cc_pin_oe & 16'h005F}, 32'h53, "pin drivers");
    step;
    step;
    axw(32'h18, 32'hFFFF, 2'h0);
    es = 16'h0;
    axw(32'h14, 32'hFFFF, 2'h0);
    axw(32'h04, 32'hFFFD, 2'h0);
    cnt = 32'hFFFD;
    step;
    step;
    axw(32'h1C, 32'h0, 2'h0);
    en = 0;
    step;
    step;
    axw(32'h1C, 32'hFFFF, 2'h0);
    en = 32'hFFFF;
    for (i = 0; i < 3; i++) begin
      md[5 + i + (i > 0)] = i + 1;
      axw(32'h40 + 4 * (5 + i + (i > 0)), 2 * i + 3, 2'h0);
    end
    for (i = 0; i < 6; i++) begin
      r = cr[i];
      v = $urandom & 32'hFFFF;
      axw(32'h0C, v, 2'h0);
      pp.set_pin(r, cl[i][0]);
      if (ce[i] == 1) begin
        cap[r] = v;
        es[r] = 1'b1;
      end
      axr(32'h80 + 4 * r, cap[r], 32'hFFFF, 2'h0);
      axr(32'h14, {16'h0, es}, 32'hFFFF, 2'h0);
    end
    chk({31'h0, irq}, 32'h1, "capture interrupt");
    axw(32'h00, 32'hD0B, 2'h0);
    axw(32'h0C, 32'h10, 2'h0);
    repeat (3) pp.ext_pulse(1);
    axr(32'h0C, 32'h13, 32'hFFFF, 2'h0);
    axw(32'h00, 32'hF0B, 2'h0);
    repeat (2) pp.ext_pulse(1);
    axr(32'h0C, 32'h17, 32'hFFFF, 2'h0);
    // Over 64 edges a divide-by-eight tick fires exactly eight times, whatever the phase.
    axw(32'h00, 32'h1010B, 2'h0);
    axw(32'h0C, 32'h100, 2'h0);
    repeat (63) @(posedge aclk);
    axr(32'h0C, 32'h108, 32'hFFFF, 2'h0);
    axw(32'h00, 32'h10B, 2'h0);
    axw(32'h0C, 32'h100, 2'h0);
    repeat (63) @(posedge aclk);
    axr(32'h0C, 32'h140, 32'hFFFF, 2'h0);
    tally_and_finish;
  end
endmodule // capture_compare_array_unit_tb
bind capture_compare_array_unit capture_compare_array_unit_chk chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cc_irq_node, .irq);
